// ===== d8tpwm_regs.vh
// Register offsets, field positions and reset values of the dual timer
`ifndef D8TPWM_REGS_VH
`define D8TPWM_REGS_VH

// IO addresses
`define D8TPWM_TIMER_A_CONTROL 8'h30
`define D8TPWM_TIMER_A_COUNT   8'h31
`define D8TPWM_TIMER_A_DIVIDER 8'h32
`define D8TPWM_TIMER_A_LIMIT   8'h33
`define D8TPWM_TIMER_B_CONTROL 8'h34
`define D8TPWM_TIMER_B_COUNT   8'h35
`define D8TPWM_TIMER_B_DIVIDER 8'h36
`define D8TPWM_TIMER_B_LIMIT   8'h37

// Control register fields
`define D8TPWM_CTL_SRC_HI      7
`define D8TPWM_CTL_SRC_LO      4
`define D8TPWM_CTL_OUT_HI      3
`define D8TPWM_CTL_OUT_LO      2
`define D8TPWM_CTL_MODE        1
`define D8TPWM_CTL_INV         0

// Divider register fields
`define D8TPWM_DIV_RES         7
`define D8TPWM_DIV_PRE_HI      6
`define D8TPWM_DIV_PRE_LO      5
`define D8TPWM_DIV_SCL_HI      4
`define D8TPWM_DIV_SCL_LO      0

// Clock source codes
`define D8TPWM_SRC_STOP        4'h0
`define D8TPWM_SRC_SYS         4'h1
`define D8TPWM_SRC_FAST        4'h2
`define D8TPWM_SRC_EXT         4'h3
`define D8TPWM_SRC_SLOW        4'h4
`define D8TPWM_SRC_COMP        4'h5
`define D8TPWM_SRC_A0_RISE     4'h8
`define D8TPWM_SRC_A0_FALL     4'h9
`define D8TPWM_SRC_B0_RISE     4'ha
`define D8TPWM_SRC_B0_FALL     4'hb
`define D8TPWM_SRC_A4_RISE     4'hc
`define D8TPWM_SRC_A4_FALL     4'hd

// Output routing codes
`define D8TPWM_OUT_NONE        2'h0
`define D8TPWM_OUT_PIN1        2'h1
`define D8TPWM_OUT_PIN2        2'h2
`define D8TPWM_OUT_PIN3        2'h3

// Reset values
`define D8TPWM_RST_CONTROL     8'h00
`define D8TPWM_RST_COUNT       8'h00
`define D8TPWM_RST_DIVIDER     8'h00
`define D8TPWM_RST_LIMIT       8'h00

`endif

// ===== d8tpwm_timer.v
// One timer channel: two-stage divider, counter and waveform
`timescale 1ns/1ps
`include "d8tpwm_regs.vh"
module d8tpwm_timer #(
    parameter LOW_RES_BITS = 6
) (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst,
    // Settings
    input  wire       srcTick,
    input  wire       pwmMode,
    input  wire       lowRes,
    input  wire [1:0] preSel,
    input  wire [4:0] scaler,
    input  wire [7:0] limit,
    // Software access to the counter
    input  wire       cntWrEn,
    input  wire [7:0] cntWrData,
    // Results
    output reg  [7:0] count,
    output reg        wave
);

    reg  [5:0] preCnt;
    reg  [4:0] sclCnt;
    reg  [5:0] preMask;
    reg  [7:0] resMask;
    reg  [7:0] next_count;
    wire       preTick;
    wire       advance;

    // Pre-divider masks for divide by 1, 4, 16 and 64
    always @* begin
        case (preSel)
            2'h0:    preMask = 6'h00;
            2'h1:    preMask = 6'h03;
            2'h2:    preMask = 6'h0f;
            default: preMask = 6'h3f;
        endcase
        resMask = lowRes ? ((8'h01 << LOW_RES_BITS) - 8'h01) : 8'hff;
    end

    assign preTick = srcTick && ((preCnt & preMask) == preMask);
    assign advance = preTick && (sclCnt >= scaler);

    // Pre-divider and scaler counters
    always @(posedge clk_sys) begin
        if (rst) begin
            preCnt <= 6'h00;
            sclCnt <= 5'h00;
        end else begin
            if (srcTick) begin
                preCnt <= preTick ? 6'h00 : preCnt + 6'h01;
            end
            if (preTick) begin
                sclCnt <= advance ? 5'h00 : sclCnt + 5'h01;
            end
        end
    end

    // Next count: wrap at the limit, or at the resolution top in PWM
    always @*  begin
        if (pwmMode) begin
            next_count = (count + 8'h01) & resMask;
        end else if (count == limit) begin
            next_count = 8'h00;
        end else begin
            next_count = count + 8'h01;
        end
    end

    // Counter and waveform; a software write beats a count step
    always @(posedge clk_sys) begin
        if (rst) begin
            count <= `D8TPWM_RST_COUNT;
            wave  <= 1'b0;
        end else if (cntWrEn) begin
            count <= cntWrData;
        end else if (advance) begin
            count <= next_count;
            if (pwmMode) begin
                wave <= (next_count & resMask) < (limit & resMask);
            end else if (count == limit) begin
                wave <= ~wave;
            end
        end
    end

endmodule // d8tpwm_timer

// ===== d8tpwm_top.v
// Dual 8-bit timer with PWM: IO registers, clock sources, pin routing
//
// How it works
// - Source field bits 7-4 pick stop, system, fast, external, slow, comparator.
// - Codes 8 to 13 count rising/falling edges of three pins; others reserved.
// - Timer A output field routes to none, B2, A3 or B4.
// - Timer B output field routes to none, B5, B6 or B7.
// - Control bit 1 picks period mode when clear, PWM when set.
// - Control bit 0 inverts the timer output when set.
// - Each timer has a readable, writable 8-bit counter, reset to zero.
// - Divider bit 7 picks 8-bit or reduced PWM resolution.
// - Divider bits 6-5 pre-divide by 1, 4, 16, 64; write-only.
// - Timer B has a write-only limit register at address 0x37.
`timescale 1ns/1ps
`include "d8tpwm_regs.vh"
module d8tpwm_top #(
    parameter FAST_OSC_DOUBLE = 0,
    parameter LOW_RES_BITS    = 6
) (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst,
    // IO register port
    input  wire [7:0] ioAddr,
    input  wire       ioWrEn,
    input  wire [7:0] ioWrData,
    input  wire       ioRdEn,
    output reg  [7:0] ioRdData,
    // Asynchronous clock sources
    input  wire       fastInternalOsc,
    input  wire       externalCrystalOsc,
    input  wire       slowInternalOsc,
    input  wire       comparatorOut,
    // Edge inputs
    input  wire       portALineZero,
    input  wire       portBLineZero,
    input  wire       portALineFour,
    // Timer A pins
    output reg        portBLineTwoOut,
    output reg        portBLineTwoEn,
    output reg        portALineThreeOut,
    output reg        portALineThreeEn,
    output reg        portBLineFourOut,
    output reg        portBLineFourEn,
    // Timer B pins
    output reg        portBLineFiveOut,
    output reg        portBLineFiveEn,
    output reg        portBLineSixOut,
    output reg        portBLineSixEn,
    output reg        portBLineSevenOut,
    output reg        portBLineSevenEn
);

    // Software-visible state
    reg  [7:0] timerAControl;
    reg  [7:0] timerADivider;
    reg  [7:0] timerALimit;
    reg  [7:0] timerBControl;
    reg  [7:0] timerBDivider;
    reg  [7:0] timerBLimit;
    wire [7:0] timerACount;
    wire [7:0] timerBCount;
    wire       waveA;
    wire       waveB;

    // Synchroniser chains: stage 1, stage 2, then an edge history stage
    reg  [6:0] syncOne;
    reg  [6:0] syncTwo;
    reg  [6:0] syncLast;
    wire [6:0] asyncIn;
    wire [6:0] riseTick;
    wire [6:0] fallTick;
    reg        tickA;
    reg        tickB;

    assign asyncIn = {portALineFour, portBLineZero, portALineZero,
                      comparatorOut, slowInternalOsc, externalCrystalOsc,
                      fastInternalOsc};

    // Three flops per input; edge logic compares the second stage with the history stage
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
            always @(posedge clk_sys) begin
                if (rst) begin
                    syncOne[gi]  <= 1'b0;
                    syncTwo[gi]  <= 1'b0;
                    syncLast[gi] <= 1'b0;
                end else begin
                    syncOne[gi]  <= asyncIn[gi];
                    syncTwo[gi]  <= syncOne[gi];
                    syncLast[gi] <= syncTwo[gi];
                end
            end
            assign riseTick[gi] = syncTwo[gi] & ~syncLast[gi];
            assign fallTick[gi] = ~syncTwo[gi] & syncLast[gi];
        end
    endgenerate

    // Source tick mux; oscillators must run well below half of clk_sys
    function srcSel;
        input [3:0] code;
        input [6:0] rise;
        input [6:0] fall;
        begin
            case (code)
                `D8TPWM_SRC_SYS:     srcSel = 1'b1;
                `D8TPWM_SRC_FAST:    srcSel = (FAST_OSC_DOUBLE != 0) ?
                                     (rise[0] | fall[0]) : rise[0];
                `D8TPWM_SRC_EXT:     srcSel = rise[1];
                `D8TPWM_SRC_SLOW:    srcSel = rise[2];
                `D8TPWM_SRC_COMP:    srcSel = rise[3];
                `D8TPWM_SRC_A0_RISE: srcSel = rise[4];
                `D8TPWM_SRC_A0_FALL: srcSel = fall[4];
                `D8TPWM_SRC_B0_RISE: srcSel = rise[5];
                `D8TPWM_SRC_B0_FALL: srcSel = fall[5];
                `D8TPWM_SRC_A4_RISE: srcSel = rise[6];
                `D8TPWM_SRC_A4_FALL: srcSel = fall[6];
                default:             srcSel = 1'b0; // Stop and reserved
            endcase
        end
    endfunction

    always @* begin
        tickA = srcSel(timerAControl[`D8TPWM_CTL_SRC_HI:`D8TPWM_CTL_SRC_LO],
                       riseTick, fallTick);
        tickB = srcSel(timerBControl[`D8TPWM_CTL_SRC_HI:`D8TPWM_CTL_SRC_LO],
                       riseTick, fallTick);
    end

    // Register writes
    always @(posedge clk_sys) begin
        if (rst) begin
            timerAControl <= `D8TPWM_RST_CONTROL;
            timerADivider <= `D8TPWM_RST_DIVIDER;
            timerALimit   <= `D8TPWM_RST_LIMIT;
            timerBControl <= `D8TPWM_RST_CONTROL;
            timerBDivider <= `D8TPWM_RST_DIVIDER;
            timerBLimit   <= `D8TPWM_RST_LIMIT;
        end else if (ioWrEn) begin
            case (ioAddr)
                `D8TPWM_TIMER_A_CONTROL: timerAControl <= ioWrData;
                `D8TPWM_TIMER_A_DIVIDER: timerADivider <= ioWrData;
                `D8TPWM_TIMER_A_LIMIT:   timerALimit   <= ioWrData;
                `D8TPWM_TIMER_B_CONTROL: timerBControl <= ioWrData;
                `D8TPWM_TIMER_B_DIVIDER: timerBDivider <= ioWrData;
                `D8TPWM_TIMER_B_LIMIT:   timerBLimit   <= ioWrData;
                default: ;
            endcase
        end
    end

    // Read data; divider and limit are write-only and read as zero
    always @(posedge clk_sys) begin
        if (rst) begin
            ioRdData <= 8'h00;
        end else if (ioRdEn) begin
            case (ioAddr)
                `D8TPWM_TIMER_A_CONTROL: ioRdData <= timerAControl;
                `D8TPWM_TIMER_A_COUNT:   ioRdData <= timerACount;
                `D8TPWM_TIMER_B_CONTROL: ioRdData <= timerBControl;
                `D8TPWM_TIMER_B_COUNT:   ioRdData <= timerBCount;
                default:                 ioRdData <= 8'h00;
            endcase
        end
    end

    // Timer A channel
    d8tpwm_timer #(
        .LOW_RES_BITS (LOW_RES_BITS)
    ) u_timerA (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .srcTick   (tickA),
        .pwmMode   (timerAControl[`D8TPWM_CTL_MODE]),
        .lowRes    (timerADivider[`D8TPWM_DIV_RES]),
        .preSel    (timerADivider[`D8TPWM_DIV_PRE_HI:`D8TPWM_DIV_PRE_LO]),
        .scaler    (timerADivider[`D8TPWM_DIV_SCL_HI:`D8TPWM_DIV_SCL_LO]),
        .limit     (timerALimit),
        .cntWrEn   (ioWrEn && (ioAddr == `D8TPWM_TIMER_A_COUNT)),
        .cntWrData (ioWrData),
        .count     (timerACount),
        .wave      (waveA)
    );

    // Timer B channel
    d8tpwm_timer #(
        .LOW_RES_BITS (LOW_RES_BITS)
    ) u_timerB (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .srcTick   (tickB),
        .pwmMode   (timerBControl[`D8TPWM_CTL_MODE]),
        .lowRes    (timerBDivider[`D8TPWM_DIV_RES]),
        .preSel    (timerBDivider[`D8TPWM_DIV_PRE_HI:`D8TPWM_DIV_PRE_LO]),
        .scaler    (timerBDivider[`D8TPWM_DIV_SCL_HI:`D8TPWM_DIV_SCL_LO]),
        .limit     (timerBLimit),
        .cntWrEn   (ioWrEn && (ioAddr == `D8TPWM_TIMER_B_COUNT)),
        .cntWrData (ioWrData),
        .count     (timerBCount),
        .wave      (waveB)
    );

    // Polarity and routing, registered so pins never glitch
    wire       outA = waveA ^ timerAControl[`D8TPWM_CTL_INV];
    wire       outB = waveB ^ timerBControl[`D8TPWM_CTL_INV];
    wire [1:0] selA = timerAControl[`D8TPWM_CTL_OUT_HI:`D8TPWM_CTL_OUT_LO];
    wire [1:0] selB = timerBControl[`D8TPWM_CTL_OUT_HI:`D8TPWM_CTL_OUT_LO];

    always @(posedge clk_sys) begin
        if (rst) begin
            portBLineTwoOut   <= 1'b0;
            portBLineTwoEn    <= 1'b0;
            portALineThreeOut <= 1'b0;
            portALineThreeEn  <= 1'b0;
            portBLineFourOut  <= 1'b0;
            portBLineFourEn   <= 1'b0;
            portBLineFiveOut  <= 1'b0;
            portBLineFiveEn   <= 1'b0;
            portBLineSixOut   <= 1'b0;
            portBLineSixEn    <= 1'b0;
            portBLineSevenOut <= 1'b0;
            portBLineSevenEn  <= 1'b0;
        end else begin
            portBLineTwoEn    <= (selA == `D8TPWM_OUT_PIN1);
            portALineThreeEn  <= (selA == `D8TPWM_OUT_PIN2);
            portBLineFourEn   <= (selA == `D8TPWM_OUT_PIN3);
            portBLineTwoOut   <= (selA == `D8TPWM_OUT_PIN1) & outA;
            portALineThreeOut <= (selA == `D8TPWM_OUT_PIN2) & outA;
            portBLineFourOut  <= (selA == `D8TPWM_OUT_PIN3) & outA;
            portBLineFiveEn   <= (selB == `D8TPWM_OUT_PIN1);
            portBLineSixEn    <= (selB == `D8TPWM_OUT_PIN2);
            portBLineSevenEn  <= (selB == `D8TPWM_OUT_PIN3);
            portBLineFiveOut  <= (selB == `D8TPWM_OUT_PIN1) & outB;
            portBLineSixOut   <= (selB == `D8TPWM_OUT_PIN2) & outB;
            portBLineSevenOut <= (selB == `D8TPWM_OUT_PIN3) & outB;
        end
    end

endmodule // d8tpwm_top

// ===== d8tpwm_chk_assertions.sv
// Port-level assertions for the dual timer
`timescale 1ns/1ps
module d8tpwm_chk (
    // Clock, reset and IO port
    input wire       clk_sys,
    input wire       rst,
    input wire [7:0] ioAddr,
    input wire       ioWrEn,
    input wire [7:0] ioWrData,
    input wire       ioRdEn,
    input wire [7:0] ioRdData,
    // Timer A pins
    input wire       portBLineTwoOut,
    input wire       portBLineTwoEn,
    input wire       portALineThreeOut,
    input wire       portALineThreeEn,
    input wire       portBLineFourOut,
    input wire       portBLineFourEn,
    // Timer B pins
    input wire       portBLineFiveOut,
    input wire       portBLineFiveEn,
    input wire       portBLineSixOut,
    input wire       portBLineSixEn,
    input wire       portBLineSevenOut,
    input wire       portBLineSevenEn
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Pin groups, timer A low
    wire [5:0] pinEn = {portBLineSevenEn, portBLineSixEn, portBLineFiveEn,
        portBLineFourEn, portALineThreeEn, portBLineTwoEn};
    wire [5:0] pinOut = {portBLineSevenOut, portBLineSixOut,
        portBLineFiveOut, portBLineFourOut, portALineThreeOut,
        portBLineTwoOut};

    pin_gate_a: assert property ((pinOut & ~pinEn) == 6'h00)
        else $error("pin driven high while not enabled");
    route_a_a: assert property ($onehot0(pinEn[2:0]))
        else $error("timer A drives more than one pin");
    route_b_a: assert property ($onehot0(pinEn[5:3]))
        else $error("timer B drives more than one pin");
    div_read_a: assert property (ioRdEn && (ioAddr == 8'h32 ||
        ioAddr == 8'h36) |=> ioRdData == 8'h00)
        else $error("divider read not zero");
    limit_read_a: assert property (ioRdEn && (ioAddr == 8'h33 ||
        ioAddr == 8'h37) |=> ioRdData == 8'h00)
        else $error("limit read not zero");
    rd_hold_a: assert property (!ioRdEn |=> $stable(ioRdData))
        else $error("read data moved without a read");
    ctl_back_a: assert property (ioWrEn && ioAddr == 8'h30 ##1
        ioRdEn && !ioWrEn && ioAddr == 8'h30
        |=> ioRdData == $past(ioWrData, 2))
        else $error("control readback differs from write");
    cnt_back_a: assert property (ioWrEn && ioAddr == 8'h31 ##1
        ioRdEn && !ioWrEn && ioAddr == 8'h31
        |=> ioRdData == $past(ioWrData, 2))
        else $error("counter readback differs from write");
    rst_quiet_a: assert property (disable iff (1'b0) rst
        |=> ioRdData == 8'h00 && pinEn == 6'h00)
        else $error("outputs not quiet after reset");
endmodule // d8tpwm_chk

bind d8tpwm_top d8tpwm_chk chk_u (.clk_sys, .rst, .ioAddr, .ioWrEn,
    .ioWrData, .ioRdEn, .ioRdData, .portBLineTwoOut, .portBLineTwoEn,
    .portALineThreeOut, .portALineThreeEn, .portBLineFourOut,
    .portBLineFourEn, .portBLineFiveOut, .portBLineFiveEn,
    .portBLineSixOut, .portBLineSixEn, .portBLineSevenOut,
    .portBLineSevenEn);

// ===== d8tpwm_pins_model.sv
// Source line model: oscillators, comparator and edge pins
`timescale 1ns/1ps
module d8tpwm_pins_model (
    // fast, ext, slow, comp, A0, B0, A4
    output reg [6:0] srcLine
);
    // Lines stand still between bursts, so counts are exact
    initial srcLine = 7'h00;
    // Slow pulses so the 2FF synchronisers see every edge
    task pulse(input integer idx, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                #23 srcLine[idx] = 1'b1;
                #23 srcLine[idx] = 1'b0;
            end
        end
    endtask
endmodule // d8tpwm_pins_model

// ===== dual_8bit_timer_pwm_tb_top.sv
// Self-checking bench for the dual 8-bit timer
`timescale 1ns/1ps
module dual_8bit_timer_pwm_tb_top;
    localparam LRB = 6;
    reg        clk_sys;
    reg        rst;
    reg  [7:0] ioAddr;
    reg        ioWrEn;
    reg  [7:0] ioWrData;
    reg        ioRdEn;
    wire [7:0] ioRdData;
    wire [6:0] srcLine;
    wire [5:0] pinOut;
    wire [5:0] pinEn;
    integer    num_errors;
    integer    samples_checked;
    integer    seed;
    integer    cyc;
    integer    t, k, n, w, e, idx;
    reg  [7:0] b;
    reg        rdSeen;
    reg  [7:0] expQ[$];

    d8tpwm_pins_model pm_u (.srcLine(srcLine));
    d8tpwm_top #(.FAST_OSC_DOUBLE(0), .LOW_RES_BITS(LRB)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
        .ioWrData(ioWrData), .ioRdEn(ioRdEn), .ioRdData(ioRdData),
        .fastInternalOsc(srcLine[0]), .externalCrystalOsc(srcLine[1]),
        .slowInternalOsc(srcLine[2]), .comparatorOut(srcLine[3]),
        .portALineZero(srcLine[4]), .portBLineZero(srcLine[5]),
        .portALineFour(srcLine[6]),
        .portBLineTwoOut(pinOut[0]), .portBLineTwoEn(pinEn[0]),
        .portALineThreeOut(pinOut[1]), .portALineThreeEn(pinEn[1]),
        .portBLineFourOut(pinOut[2]), .portBLineFourEn(pinEn[2]),
        .portBLineFiveOut(pinOut[3]), .portBLineFiveEn(pinEn[3]),
        .portBLineSixOut(pinOut[4]), .portBLineSixEn(pinEn[4]),
        .portBLineSevenOut(pinOut[5]), .portBLineSevenEn(pinEn[5]));

    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task wrap_up;
        begin
            if (num_errors == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task check(input [15:0] seen, input [15:0] exp, input string nm);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // All bus changes land on the falling edge
    task bus(input we, input re, input [7:0] a, input [7:0] d);
        begin
            @(negedge clk_sys);
            ioWrEn = we;
            ioRdEn = re;
            ioAddr = a;
            ioWrData = d;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task rd(input [7:0] a, input [7:0] x);
        begin
            bus(1'b0, 1'b1, a, 8'h00);
            expQ.push_back(x);
        end
    endtask
    task idle(input integer c);
        begin
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            repeat (c) @(negedge clk_sys);
        end
    endtask
    // First wait aligns to a change, second one measures
    task span(output integer c);
        reg l;
        repeat (2) begin
            c = 0;
            l = pinOut[0];
            while (pinOut[0] === l && c < 5000) begin
                @(negedge clk_sys);
                c = c + 1;
            end
        end
    endtask

    // Read data stands from the edge after the strobe
    always @(posedge clk_sys) rdSeen <= ioRdEn & ~rst;
    always @(negedge clk_sys)
        if (rdSeen === 1'b1) check(ioRdData, expQ.pop_front(), "ioRdData");

    // Hang guard, far above the expected run length
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end

    initial begin
        seed = 8473;
        num_errors = 0;
        samples_checked = 0;
        cyc = 0;
        rst = 1'b1;
        {ioWrEn, ioRdEn, ioAddr, ioWrData} = 18'h00000;
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        // Reset values, refused writes and reads
        for (k = 0; k < 8; k = k + 1) rd(8'h30 + k[7:0], 8'h00);
        wr(8'h50, 8'hff);
        rd(8'h50, 8'h00);
        for (t = 0; t < 2; t = t + 1) begin
            b = t ? 8'h34 : 8'h30;
            v_loop: begin
                w = $random(seed);
                wr(b, {4'h0, w[3:0]});
                rd(b, {4'h0, w[3:0]});
                wr(b + 8'h01, w[15:8]);
                rd(b + 8'h01, w[15:8]);
            end
            for (k = 0; k < 4; k = k + 1) begin
                wr(b, {4'h0, k[1:0], 2'b00});
                idle(3);
                e = (k == 0) ? 0 : 1 << (k - 1 + 3 * t);
                check({10'h000, pinEn}, e[15:0], "pinEn");
            end
            wr(b + 8'h03, 8'hff);
            for (k = 0; k < 15; k = k + 1) if (k != 1) begin
                n = 1 + {$random(seed)} % 5;
                w = ((k >= 2 && k <= 5) || (k >= 8 && k <= 13)) ? 1 : 0;
                idx = !w ? 0 : (k < 6) ? k - 2 : 4 + (k - 8) / 2;
                wr(b + 8'h01, 8'h00);
                wr(b, {k[3:0], 4'h0});
                idle(1);
                pm_u.pulse(idx, n);
                idle(8);
                wr(b, 8'h00);
                rd(b + 8'h01, w ? n[7:0] : 8'h00);
            end
        end
        // Period mode through both divider stages
        wr(8'h33, 8'h01);
        for (k = 0; k < 4; k = k + 1) begin
            n = {$random(seed)} % 4;
            wr(8'h32, {1'b0, k[1:0], n[4:0]});
            wr(8'h30, 8'h14);
            idle(1);
            span(w);
            e = (1 << (2 * k)) * (n + 1) * 2;
            check(w[15:0], e[15:0], "halfPeriod");
        end
        // PWM duty: full width, reduced width, inverted
        wr(8'h33, 8'h48);
        for (k = 0; k < 3; k = k + 1) begin
            wr(8'h32, (k == 1) ? 8'h80 : 8'h00);
            wr(8'h30, (k == 2) ? 8'h17 : 8'h16);
            idle(600);
            w = 0;
            repeat (256) begin
                @(negedge clk_sys);
                w = w + pinOut[0];
            end
            e = (k == 0) ? 72 : (k == 2) ? 184
                : (256 >> LRB) * (72 & ((1 << LRB) - 1));
            check(w[15:0], e[15:0], "highCycles");
        end
        // Pins A3, B4, B5, B6 and B7 each carry their own timer's PWM wave
        wr(8'h37, 8'h48);
        for (k = 1; k < 6; k = k + 1) begin
            n = (k < 3) ? k + 1 : k - 2;
            wr((k < 3) ? 8'h30 : 8'h34, {4'h1, n[1:0], 2'b10});
            idle(300);
            w = 0;
            repeat (256) begin
                @(negedge clk_sys);
                w = w + pinOut[k];
            end
            check(w[15:0], 16'h0048, "pinHigh");
        end
        idle(3);
        wrap_up;
    end
endmodule // dual_8bit_timer_pwm_tb_top
